// *** hw/touch_pkg.sv ***
// shared constants, parameter map and carrier types of the touch processor
package touch_pkg;

	localparam int NUM_SENSE     = 8;
	localparam int CLK_MHZ       = 40;
	localparam int TIMER_UNIT_US = 1000;
	localparam int UNIT_CYCLES   = TIMER_UNIT_US * CLK_MHZ;

	localparam int SHADOW_DEPTH = 32;
	localparam int LOAD_WORDS   = 24;

	// shadow parameter word addresses
	localparam logic [4:0] A_ENABLE      = 5'h00;
	localparam logic [4:0] A_SLIDER      = 5'h01;
	localparam logic [4:0] A_THRESH      = 5'h02;
	localparam logic [4:0] A_HYST        = 5'h03;
	localparam logic [4:0] A_NOISE_POS   = 5'h04;
	localparam logic [4:0] A_NOISE_NEG   = 5'h05;
	localparam logic [4:0] A_STEP        = 5'h06;
	localparam logic [4:0] A_SLD_MAX     = 5'h07;
	localparam logic [4:0] A_COMP_PERIOD = 5'h08;
	localparam logic [4:0] A_WAKE_SEQ    = 5'h09;
	localparam logic [4:0] A_ACTIVE_PER  = 5'h0A;
	localparam logic [4:0] A_DOZE_PER    = 5'h0B;
	localparam logic [4:0] A_PASSIVE     = 5'h0C;
	localparam logic [4:0] A_SENS_BASE   = 5'h10;

	// wake sequence word: enable, length, four 3-bit button indices
	localparam int WAKE_EN_BIT  = 15;
	localparam int WAKE_LEN_LSB = 12;

	localparam int         AVG_SHIFT   = 4;
	localparam logic [2:0] COMP_PASSES = 3'h4;

	typedef enum logic [1:0] {MODE_ACTIVE, MODE_DOZE, MODE_SLEEP} mode_t;

	typedef struct packed {
		logic [7:0]       en;
		logic [7:0]       smask;
		logic [15:0]      thr;
		logic [15:0]      hyst;
		logic [15:0]      npos;
		logic [15:0]      nneg;
		logic [15:0]      step;
		logic [15:0]      smax;
		logic [15:0]      cper;
		logic [15:0]      wseq;
		logic [15:0]      aper;
		logic [15:0]      dper;
		logic [15:0]      passive;
		logic [7:0][7:0]  sens;
	} params_t;

	typedef struct packed {
		logic        start;
		logic [2:0]  sel;
		logic [7:0]  cycles;
		logic [15:0] comp_val;
	} afe_req_t;

	typedef struct packed {
		logic [7:0]  btn_on;
		logic        slider_on;
		logic [15:0] slider_pos;
		mode_t       mode;
	} status_t;

	typedef struct packed {
		logic button;
		logic slider;
		logic move_lo;
		logic move_hi;
		logic mode_entered;
		logic comp_done;
	} event_t;

	typedef struct packed {
		logic        mode_wr;
		mode_t       mode;
		logic        comp_req;
		logic        shadow_wr;
		logic [4:0]  addr;
		logic [15:0] data;
	} host_cmd_t;

	// fixed quick start parameter set: six-sensor slider plus two buttons
	function automatic logic [15:0] quick_start_word(input logic [4:0] a);
		logic [15:0] w;
		w = 16'h0000;
		case (a)
			A_ENABLE:      w = 16'h00FF;
			A_SLIDER:      w = 16'h00FC;
			A_THRESH:      w = 16'h0040;
			A_HYST:        w = 16'h0008;
			A_NOISE_POS:   w = 16'h0020;
			A_NOISE_NEG:   w = 16'h0020;
			A_STEP:        w = 16'h0010;
			A_SLD_MAX:     w = 16'h00FF;
			A_COMP_PERIOD: w = 16'h0000;
			A_WAKE_SEQ:    w = 16'h0000;
			A_ACTIVE_PER:  w = 16'h001E;
			A_DOZE_PER:    w = 16'h00C3;
			A_PASSIVE:     w = 16'h0064;
			default:       w = (a >= A_SENS_BASE) ? 16'h0020 : 16'h0000;
		endcase
		return w;
	endfunction

endpackage

// *** hw/shadow_parameter_memory.sv ***
// shadow parameter memory: one write port, registered read data
`timescale 1ns/1ps
`default_nettype none
module shadow_parameter_memory (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wr_en_i,
	input  wire logic [4:0]  wr_addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic [4:0]  rd_addr_i,
	output logic      [15:0] rd_data_o
);
	logic [15:0] mem_q [touch_pkg::SHADOW_DEPTH];

	// contents are not reset; the loader refills every used word after reset
	always_ff @(posedge mclk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= 16'h0000;
		end else begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end
endmodule
`default_nettype wire

// *** hw/touch_proc.sv ***
// scan sequencer, filtering, button/slider decisions, compensation and mode control
`timescale 1ns/1ps
`default_nettype none
module touch_proc #(
	parameter int unsigned unit_cycles = touch_pkg::UNIT_CYCLES
) (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 afe_done_i,
	input  wire logic [15:0]          afe_ticks_i,
	input  wire touch_pkg::host_cmd_t host_i,
	input  wire logic                 irq_clear_i,
	input  wire logic                 nvm_valid_i,
	input  wire logic [15:0]          nvm_data_i,
	output logic      [4:0]           nvm_addr_o,
	output touch_pkg::afe_req_t       afe_o,
	output touch_pkg::status_t        status_o,
	output touch_pkg::event_t         event_o,
	output logic                      interrupt_out_n_o
);
	typedef enum logic [2:0] {ST_LOAD, ST_FETCH, ST_WAIT, ST_PICK, ST_SENSE, ST_PROC, ST_FIN} st_t;

	typedef struct packed {
		st_t                 st;
		touch_pkg::mode_t    mode;
		logic                load_ph;
		logic [4:0]          idx;
		touch_pkg::params_t  prm;
		logic [31:0]         unit_cnt;
		logic [15:0]         ms_cnt;
		logic                d1;
		logic                d2;
		logic                d3;
		logic [15:0]         t1;
		logic [15:0]         t2;
		logic [7:0][15:0]    comp_val;
		logic [7:0][15:0]    avg;
		logic [7:0][15:0]    raw;
		logic [7:0]          btn;
		logic [7:0]          btn_prev;
		logic                sld_prev;
		logic [15:0]         pos;
		logic [18:0]         sum_d;
		logic [21:0]         sum_wd;
		logic [2:0]          rank;
		logic                comp_act;
		logic [2:0]          comp_pass;
		logic                comp_pend;
		logic                noise_hit;
		logic [15:0]         per_cnt;
		logic [15:0]         pas_cnt;
		logic [1:0]          seq_pos;
		logic                seq_armed;
		logic                mode_pend;
		logic [4:0]          nvm_addr;
		touch_pkg::afe_req_t afe;
		touch_pkg::status_t  stat;
		touch_pkg::event_t   evt;
		logic                irq_n;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic        mem_wr;
	logic [4:0]  mem_waddr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;

	function automatic logic signed [17:0] sx(input logic [15:0] v);
		return $signed({{2{v[15]}}, v});
	endfunction

	function automatic logic signed [17:0] zx(input logic [15:0] v);
		return $signed({2'b00, v});
	endfunction

	function automatic touch_pkg::params_t take_word(input touch_pkg::params_t p,
		input logic [4:0] a, input logic [15:0] d);
		touch_pkg::params_t r;
		r = p;
		case (a)
			touch_pkg::A_ENABLE:      r.en = d[7:0];
			touch_pkg::A_SLIDER:      r.smask = d[7:0];
			touch_pkg::A_THRESH:      r.thr = d;
			touch_pkg::A_HYST:        r.hyst = d;
			touch_pkg::A_NOISE_POS:   r.npos = d;
			touch_pkg::A_NOISE_NEG:   r.nneg = d;
			touch_pkg::A_STEP:        r.step = d;
			touch_pkg::A_SLD_MAX:     r.smax = d;
			touch_pkg::A_COMP_PERIOD: r.cper = d;
			touch_pkg::A_WAKE_SEQ:    r.wseq = d;
			touch_pkg::A_ACTIVE_PER:  r.aper = d;
			touch_pkg::A_DOZE_PER:    r.dper = d;
			touch_pkg::A_PASSIVE:     r.passive = d;
			default: begin
				if (a >= touch_pkg::A_SENS_BASE) r.sens[a[2:0]] = d[7:0];
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// parameter store

	// loader owns the write port until the copy is done; host writes are dropped meanwhile
	always_comb begin
		mem_wr    = 1'b0;
		mem_waddr = host_i.addr;
		mem_wdata = host_i.data;
		if (s_q.st == ST_LOAD) begin
			mem_wr    = s_q.load_ph;
			mem_waddr = s_q.idx;
			mem_wdata = nvm_valid_i ? nvm_data_i : touch_pkg::quick_start_word(s_q.idx);
		end else begin
			mem_wr = host_i.shadow_wr;
		end
	end

	shadow_parameter_memory u_shadow (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n_i),
		.wr_en_i   (mem_wr),
		.wr_addr_i (mem_waddr),
		.wr_data_i (mem_wdata),
		.rd_addr_i (s_q.idx),
		.rd_data_o (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [2:0]         i;
		logic signed [17:0] diff;
		logic [15:0]        avg_n;
		logic signed [17:0] dev;
		logic [15:0]        dp;
		logic [7:0]         btn_only;
		logic [7:0]         new_t;
		logic [7:0]         rel_t;
		logic               sld_on;
		logic [15:0]        pos_n;
		logic [37:0]        num;
		logic [21:0]        den;
		logic [2:0]         exp_btn;
		logic [3:0][2:0]    seq_idx;
		logic [15:0]        period;
		i        = s_q.idx[2:0];
		diff     = '0;
		avg_n    = '0;
		dev      = '0;
		dp       = '0;
		btn_only = s_q.prm.en & ~s_q.prm.smask;
		new_t    = s_q.btn & ~s_q.btn_prev & btn_only;
		rel_t    = ~s_q.btn & s_q.btn_prev & btn_only;
		sld_on   = |(s_q.btn & s_q.prm.en & s_q.prm.smask);
		pos_n    = s_q.pos;
		num      = '0;
		den      = '0;
		seq_idx  = s_q.prm.wseq[11:0];
		exp_btn  = seq_idx[s_q.seq_pos];
		period   = (s_q.mode == touch_pkg::MODE_DOZE) ? s_q.prm.dper : s_q.prm.aper;

		s_d           = s_q;
		s_d.d1        = afe_done_i;
		s_d.d2        = s_q.d1;
		s_d.d3        = s_q.d2;
		s_d.t1        = afe_ticks_i;
		s_d.t2        = s_q.t1;
		s_d.afe.start = 1'b0;
		s_d.evt       = '0;

		unique case (s_q.st)
			ST_LOAD: begin
				if (!s_q.load_ph) begin
					s_d.nvm_addr = s_q.idx;
					s_d.load_ph  = 1'b1;
				end else begin
					s_d.load_ph = 1'b0;
					s_d.idx     = s_q.idx + 5'h01;
					if (s_q.idx == 5'(touch_pkg::LOAD_WORDS - 1)) begin
						s_d.idx   = 5'h00;
						s_d.st    = ST_FETCH;
						s_d.irq_n = 1'b1;
					end
				end
			end
			ST_FETCH: begin
				if (s_q.idx != 5'h00) s_d.prm = take_word(s_q.prm, s_q.idx - 5'h01, mem_rdata);
				s_d.idx = s_q.idx + 5'h01;
				if (s_q.idx == 5'(touch_pkg::LOAD_WORDS)) begin
					s_d.idx       = 5'h00;
					s_d.sum_d     = '0;
					s_d.sum_wd    = '0;
					s_d.rank      = '0;
					s_d.noise_hit = 1'b0;
					s_d.st        = ST_PICK;
					if (s_q.comp_pend) begin
						s_d.comp_act  = 1'b1;
						s_d.comp_pass = '0;
						s_d.comp_pend = 1'b0;
					end
				end
			end
			ST_WAIT: begin
				if (s_q.mode != touch_pkg::MODE_SLEEP) begin
					s_d.unit_cnt = s_q.unit_cnt + 32'h1;
					if (s_q.unit_cnt >= 32'(unit_cycles - 1)) begin
						s_d.unit_cnt = '0;
						s_d.ms_cnt   = s_q.ms_cnt + 16'h0001;
						if (s_q.ms_cnt + 16'h0001 >= period) begin
							s_d.ms_cnt = '0;
							s_d.idx    = 5'h00;
							s_d.st     = ST_FETCH;
						end
					end
				end
			end
			ST_PICK: begin
				if (s_q.idx[3]) begin
					s_d.idx = 5'h00;
					s_d.st  = ST_PROC;
				end else if (s_q.prm.en[i]) begin
					s_d.afe.start    = 1'b1;
					s_d.afe.sel      = i;
					s_d.afe.cycles   = s_q.prm.sens[i];
					s_d.afe.comp_val = s_q.comp_val[i];
					s_d.st           = ST_SENSE;
				end else begin
					s_d.idx = s_q.idx + 5'h01;
				end
			end
			ST_SENSE: begin
				if (s_q.d2 && !s_q.d3) begin
					s_d.raw[i] = s_q.t2;
					// integrating search: residual ticks pull the offset toward zero output
					if (s_q.comp_act) s_d.comp_val[i] = s_q.comp_val[i] + s_q.t2;
					s_d.idx = s_q.idx + 5'h01;
					s_d.st  = ST_PICK;
				end
			end
			ST_PROC: begin
				if (s_q.idx[3]) begin
					s_d.st = ST_FIN;
				end else begin
					s_d.idx = s_q.idx + 5'h01;
					if (s_q.prm.en[i] && !s_q.comp_act) begin
						diff       = sx(s_q.raw[i]) - sx(s_q.avg[i]);
						avg_n      = s_q.avg[i] + 16'(diff >>> touch_pkg::AVG_SHIFT);
						s_d.avg[i] = avg_n;
						dev        = sx(s_q.raw[i]) - sx(avg_n);
						if (sx(avg_n) > zx(s_q.prm.npos) || sx(avg_n) < -zx(s_q.prm.nneg)) begin
							s_d.noise_hit = 1'b1;
						end
						if (!s_q.btn[i] && dev >= zx(s_q.prm.thr) + zx(s_q.prm.hyst)) begin
							s_d.btn[i] = 1'b1;
						end
						if (s_q.btn[i] && dev < zx(s_q.prm.thr) - zx(s_q.prm.hyst)) begin
							s_d.btn[i] = 1'b0;
						end
						if (s_q.prm.smask[i]) begin
							dp         = (dev > 18'sd0) ? dev[15:0] : 16'h0000;
							s_d.sum_d  = s_q.sum_d + 19'(dp);
							s_d.sum_wd = s_q.sum_wd + 22'(dp * s_q.rank);
							s_d.rank   = s_q.rank + 3'h1;
						end
					end
				end
			end
			ST_FIN: begin
				s_d.st = ST_WAIT;
				if (s_q.comp_act) begin
					s_d.comp_pass = s_q.comp_pass + 3'h1;
					if (s_q.comp_pass == touch_pkg::COMP_PASSES - 3'h1) begin
						s_d.comp_act      = 1'b0;
						s_d.avg           = '0;
						s_d.btn           = '0;
						s_d.evt.comp_done = 1'b1;
					end
				end else begin
					if (sld_on && s_q.rank > 3'h1 && s_q.sum_d != '0) begin
						num   = 38'(s_q.sum_wd * s_q.prm.smax);
						den   = 22'(s_q.sum_d * (s_q.rank - 3'h1));
						pos_n = 16'(num / den);
					end
					if (sld_on && s_q.sld_prev) begin
						if ({1'b0, pos_n} + {1'b0, s_q.prm.step} <= {1'b0, s_q.pos}) begin
							s_d.evt.move_lo = 1'b1;
						end
						if ({1'b0, pos_n} >= {1'b0, s_q.pos} + {1'b0, s_q.prm.step}) begin
							s_d.evt.move_hi = 1'b1;
						end
					end
					s_d.evt.button = |((s_q.btn ^ s_q.btn_prev) & btn_only);
					s_d.evt.slider = (sld_on != s_q.sld_prev) || (pos_n != s_q.pos);
					s_d.pos        = pos_n;
					s_d.sld_prev   = sld_on;
					s_d.btn_prev   = s_q.btn;
					if (s_q.noise_hit) s_d.comp_pend = 1'b1;
					s_d.per_cnt = s_q.per_cnt + 16'h0001;
					if (s_q.prm.cper != '0 && s_q.per_cnt + 16'h0001 >= s_q.prm.cper) begin
						s_d.per_cnt   = '0;
						s_d.comp_pend = 1'b1;
					end
					if (s_q.mode == touch_pkg::MODE_ACTIVE && s_q.prm.passive != '0) begin
						s_d.pas_cnt = (|(s_q.btn & s_q.prm.en)) ? 16'h0000 : s_q.pas_cnt + 16'h0001;
						if (s_d.pas_cnt >= s_q.prm.passive) begin
							s_d.mode             = touch_pkg::MODE_DOZE;
							s_d.pas_cnt          = '0;
							s_d.seq_pos          = '0;
							s_d.seq_armed        = 1'b0;
							s_d.evt.mode_entered = 1'b1;
						end
					end
					if (s_q.mode == touch_pkg::MODE_DOZE) begin
						if (!s_q.prm.wseq[touch_pkg::WAKE_EN_BIT]) begin
							if (|new_t) begin
								s_d.mode             = touch_pkg::MODE_ACTIVE;
								s_d.evt.mode_entered = 1'b1;
							end
						end else begin
							// a touch on the wrong button restarts the whole sequence
							if (|(new_t & ~(8'h01 << exp_btn))) begin
								s_d.seq_pos   = '0;
								s_d.seq_armed = 1'b0;
							end else if (new_t[exp_btn]) begin
								s_d.seq_armed = 1'b1;
							end else if (s_q.seq_armed && rel_t[exp_btn]) begin
								s_d.seq_armed = 1'b0;
								s_d.seq_pos   = s_q.seq_pos + 2'h1;
								if ({1'b0, s_q.seq_pos} + 3'h1 >=
									s_q.prm.wseq[touch_pkg::WAKE_LEN_LSB +: 3]) begin
									s_d.seq_pos          = '0;
									s_d.mode             = touch_pkg::MODE_ACTIVE;
									s_d.evt.mode_entered = 1'b1;
								end
							end
						end
					end
				end
				if (s_q.mode_pend) begin
					s_d.evt.mode_entered = 1'b1;
					s_d.mode_pend        = 1'b0;
				end
				s_d.stat.btn_on     = s_q.btn & btn_only;
				s_d.stat.slider_on  = sld_on;
				s_d.stat.slider_pos = pos_n;
				s_d.stat.mode       = s_d.mode;
			end
		endcase

		// host commands act after the automatic decisions so the host wins a tie
		if (host_i.mode_wr && s_q.st != ST_LOAD) begin
			s_d.mode      = host_i.mode;
			s_d.seq_pos   = '0;
			s_d.seq_armed = 1'b0;
			s_d.pas_cnt   = '0;
			s_d.mode_pend = (host_i.mode != touch_pkg::MODE_SLEEP);
		end
		if (host_i.comp_req && s_q.mode != touch_pkg::MODE_SLEEP) begin
			s_d.comp_pend = 1'b1;
		end

		// clear first so an event in the same cycle keeps the line asserted
		if (irq_clear_i && s_q.st != ST_LOAD) s_d.irq_n = 1'b1;
		if (s_q.st == ST_FIN && s_d.evt != '0) s_d.irq_n = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q           <= '0;
			s_q.st        <= ST_LOAD;
			s_q.mode      <= touch_pkg::MODE_ACTIVE;
			s_q.stat.mode <= touch_pkg::MODE_ACTIVE;
			s_q.comp_pend <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign nvm_addr_o        = s_q.nvm_addr;
	assign afe_o             = s_q.afe;
	assign status_o          = s_q.stat;
	assign event_o           = s_q.evt;
	assign interrupt_out_n_o = s_q.irq_n;
endmodule
`default_nettype wire

// *** verif/touch_proc_checker.sv ***
// port-level assertion checker for the touch processor
`timescale 1ns/1ps
`default_nettype none
module touch_proc_checker #(
	parameter int unsigned unit_cycles = touch_pkg::UNIT_CYCLES
) (
	input  wire touch_pkg::afe_req_t  afe_o,
	input  wire touch_pkg::status_t   status_o,
	input  wire touch_pkg::event_t    event_o,
	input  wire touch_pkg::host_cmd_t host_i,
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 afe_done_i,
	input  wire logic                 irq_clear_i,
	input  wire logic                 interrupt_out_n_o
);
	typedef struct packed {
		logic pend;
		logic ready;
		logic done;
		logic wake;
	} hlp_t;
	hlp_t hlp_q;
	hlp_t hlp_d;
	// ready stays low through the parameter load, when the interrupt is held low
	always_comb begin
		hlp_d = hlp_q;
		hlp_d.done = afe_done_i;
		if (afe_o.start)
			hlp_d.pend = 1'b1;
		if (afe_done_i && !hlp_q.done)
			hlp_d.pend = 1'b0;
		if (interrupt_out_n_o)
			hlp_d.ready = 1'b1;
		// status shows sleep until the next processing end, even after a host wake-up
		if (host_i.mode_wr)
			hlp_d.wake = (host_i.mode != touch_pkg::MODE_SLEEP);
		else if (status_o.mode != touch_pkg::MODE_SLEEP)
			hlp_d.wake = 1'b0;
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			hlp_q <= '0;
		else
			hlp_q <= hlp_d;
	end
	////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_start_pulse: assert property (afe_o.start |=> !afe_o.start)
		else $error("front-end start wider than one cycle");
	a_one_outstanding: assert property (afe_o.start |-> !hlp_q.pend)
		else $error("new start while a conversion is outstanding");
	a_done_to_start: assert property ($rose(afe_done_i) |-> !afe_o.start [*3])
		else $error("start before the result was taken");
	a_fields_hold: assert property (!afe_o.start |-> $stable(afe_o.sel) &&
		$stable(afe_o.cycles) && $stable(afe_o.comp_val))
		else $error("front-end fields moved between starts");
	a_irq_on_event: assert property (event_o != '0 |-> !interrupt_out_n_o)
		else $error("event without interrupt");
	a_irq_cause: assert property (hlp_q.ready && $fell(interrupt_out_n_o) |-> event_o != '0)
		else $error("interrupt asserted without event");
	a_irq_release: assert property (hlp_q.ready && irq_clear_i |=>
		interrupt_out_n_o || event_o != '0)
		else $error("interrupt not released by clear");
	a_btn_change: assert property ($changed(status_o.btn_on) |-> event_o.button)
		else $error("button state changed without event");
	a_slider_change: assert property ($changed(status_o.slider_on) |-> event_o.slider)
		else $error("slider state changed without event");
	a_move_low: assert property (event_o.move_lo |-> status_o.slider_on &&
		$past(status_o.slider_on) && status_o.slider_pos < $past(status_o.slider_pos))
		else $error("move low without falling position");
	a_move_high: assert property (event_o.move_hi |-> status_o.slider_on &&
		$past(status_o.slider_on) && status_o.slider_pos > $past(status_o.slider_pos))
		else $error("move high without rising position");
	a_mode_entry: assert property ($changed(status_o.mode) &&
		status_o.mode != touch_pkg::MODE_SLEEP |-> event_o.mode_entered)
		else $error("mode change without entry event");
	a_sleep_quiet: assert property ((status_o.mode == touch_pkg::MODE_SLEEP &&
		!hlp_q.wake) [*2] |-> !afe_o.start)
		else $error("sensing started in sleep");
endmodule
bind touch_proc touch_proc_checker #(
	.unit_cycles(unit_cycles)
) u_checker (
	.afe_o(afe_o),
	.status_o(status_o),
	.event_o(event_o),
	.host_i(host_i),
	.mclk_i(mclk_i),
	.rst_n_i(rst_n_i),
	.afe_done_i(afe_done_i),
	.irq_clear_i(irq_clear_i),
	.interrupt_out_n_o(interrupt_out_n_o)
);
`default_nettype wire

// *** verif/afe_model.sv ***
// behavioural sensing front end answering each start with ticks and a done level
`timescale 1ns/1ps
`default_nettype none
module afe_model #(
	parameter logic [15:0] base_ticks = 16'h0100
) (
	input  wire touch_pkg::afe_req_t req_i,
	input  wire logic [7:0][15:0]    finger_i,
	input  wire logic                mclk_i,
	input  wire logic                rst_n_i,
	output logic                     done_o,
	output logic [15:0]              ticks_o
);
	logic        slow;
	logic [15:0] v;
	int          k;
	// answers alternate prompt and slow; ticks are inverted once done drops
	initial begin
		done_o = 1'b0;
		ticks_o = 16'h0000;
		slow = 1'b0;
		forever begin
			@(negedge mclk_i);
			if (rst_n_i && req_i.start) begin
				k = int'(req_i.sel);
				slow = ~slow;
				// pad offset removed by the dac, finger grows with cycles
				v = base_ticks + 16'(k * 17) - req_i.comp_val
					+ 16'((32'(finger_i[k]) * 32'(req_i.cycles)) >> 5);
				repeat (slow ? 20 : 2) @(posedge mclk_i);
				#2 ticks_o = v;
				repeat (3) @(posedge mclk_i);
				#2 done_o = 1'b1;
				repeat (4) @(posedge mclk_i);
				#2 done_o = 1'b0;
				ticks_o = ~v;
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/touch_proc_tb_top.sv ***
// self-checking bench: front-end model, host commands and queued status notes
`timescale 1ns/1ps
`default_nettype none
module touch_proc_tb_top;
	typedef struct packed {
		logic [5:0]       m;
		logic [7:0]       b;
		logic             so;
		logic [15:0]      p;
		touch_pkg::mode_t md;
	} note_t;
	localparam touch_pkg::mode_t act = touch_pkg::MODE_ACTIVE;
	localparam touch_pkg::mode_t doze = touch_pkg::MODE_DOZE;
	logic                 mclk_i, rst_n_i, done, irq_clear, irq_n, chk, exp_so, nvm_ok;
	logic [4:0]           nvm_a;
	logic [15:0]          ticks, nvm_data, exp_p, v;
	logic [31:0]          rng;
	logic [7:0]           exp_en, exp_b;
	logic [7:0][7:0]      exp_cyc;
	logic [7:0][15:0]     finger, exp_comp;
	touch_pkg::mode_t     exp_md;
	touch_pkg::host_cmd_t host;
	touch_pkg::afe_req_t  afe;
	touch_pkg::status_t   st;
	touch_pkg::event_t    ev;
	int                   n_fail, checks_done, n_start, s;
	note_t                q[$];

	touch_proc #(.unit_cycles(4)) uut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .afe_done_i(done), .afe_ticks_i(ticks),
		.host_i(host), .irq_clear_i(irq_clear), .nvm_valid_i(nvm_ok), .nvm_data_i(nvm_data),
		.nvm_addr_o(nvm_a), .afe_o(afe), .status_o(st), .event_o(ev), .interrupt_out_n_o(irq_n)
	);
	afe_model u_afe (
		.req_i(afe), .finger_i(finger), .mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.done_o(done), .ticks_o(ticks)
	);

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		#2;
		rng = xs(rng);
		// stored set: quick start words except only inputs 0 and 1 enabled
		nvm_data = (nvm_a == touch_pkg::A_ENABLE) ? {rng[15:8], 8'h03} :
			touch_pkg::quick_start_word(nvm_a);
	end
	////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] a);
		logic [31:0] x;
		x = a ^ (a << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic boot(input logic nv);
		rst_n_i = 1'b0;
		nvm_ok  = nv;
		repeat (12) @(posedge mclk_i);
		#2 rst_n_i = 1'b1;
		for (int j = 0; j < 200 && irq_n !== 1'b1; j++)
			@(posedge mclk_i);
		cmp("load_done", 32'h1, 32'(irq_n));
	endtask
	// expected offsets once compensation has settled with the current fingers
	task automatic snap();
		for (int k = 0; k < 8; k++)
			exp_comp[k] = 16'h0100 + 16'(k * 17) + 16'((32'(finger[k]) * 32'(exp_cyc[k])) >> 5);
	endtask
	task automatic hcmd(input logic mw, input touch_pkg::mode_t md, input logic cr,
		input logic sw, input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		#2 host = '{mw, md, cr, sw, a, d};
		@(posedge mclk_i);
		#2 host = '0;
	endtask
	task automatic await_note(input logic [5:0] m);
		int i;
		q.push_back('{m, exp_b, exp_so, exp_p, exp_md});
		i = 0;
		while (q.size() > 0 && i < 30000) begin
			@(posedge mclk_i);
			i++;
		end
		if (q.size() > 0) begin
			n_fail++;
			$display("CHECK FAILED note expected event seen timeout");
			conclude();
		end
		@(posedge mclk_i);
		#2 irq_clear = 1'b1;
		@(posedge mclk_i);
		#2 irq_clear = 1'b0;
	endtask
	////////////////////////////////
	always @(negedge mclk_i) begin
		if (rst_n_i && afe.start) begin
			n_start++;
			cmp("enabled", 32'h1, 32'(exp_en[afe.sel]));
			if (chk) begin
				cmp("comp_val", 32'(exp_comp[afe.sel]), 32'(afe.comp_val));
				cmp("cycles", 32'(exp_cyc[afe.sel]), 32'(afe.cycles));
			end
		end
		if (rst_n_i && q.size() > 0) begin
			if ((6'(ev) & q[0].m) != 6'h00) begin
				cmp("status", 32'({q[0].b, q[0].so, q[0].p, q[0].md}),
					32'({st.btn_on, st.slider_on, st.slider_pos, st.mode}));
				void'(q.pop_front());
			end
		end
	end
	initial begin
		{irq_clear, chk, exp_so, exp_b, exp_p, n_fail, checks_done, n_start} = '0;
		host = '0;
		finger = '0;
		nvm_data = 16'h0000;
		rng = 32'h3168;
		exp_en = 8'hFF;
		exp_cyc = {8{8'h20}};
		exp_md = act;
		snap();
		boot(1'b0);
		hcmd(1'b0, act, 1'b0, 1'b1, touch_pkg::A_PASSIVE, 16'h0000);
		await_note(6'h01);
		chk = 1'b1;
		$display("test power_up done");
		finger[0] = 16'h004B;
		finger[1] = 16'h004C;
		exp_b = 8'h02;
		await_note(6'h20);
		finger[0] = 16'h0000;
		finger[1] = 16'h0000;
		exp_b = 8'h00;
		await_note(6'h20);
		$display("test buttons done");
		v = 16'h0060 + 16'(rng[4:0]);
		finger[7] = v;
		{exp_so, exp_p} = {1'b1, 16'h00FF};
		await_note(6'h10);
		{finger[7], finger[2], exp_p} = {16'h0000, v, 16'h0000};
		await_note(6'h08);
		{finger[2], finger[7], exp_p} = {16'h0000, v, 16'h00FF};
		await_note(6'h04);
		finger[7] = 16'h0000;
		exp_so = 1'b0;
		await_note(6'h10);
		$display("test slider done");
		chk = 1'b0;
		finger[0] = 16'h0038;
		snap();
		await_note(6'h01);
		hcmd(1'b0, act, 1'b0, 1'b1, touch_pkg::A_ENABLE, 16'h0003);
		hcmd(1'b0, act, 1'b0, 1'b1, touch_pkg::A_SENS_BASE + 5'h01, 16'h0033);
		finger[0] = 16'h0000;
		exp_cyc[1] = 8'h33;
		snap();
		hcmd(1'b0, act, 1'b1, 1'b0, 5'h00, 16'h0000);
		await_note(6'h01);
		exp_en = 8'h03;
		chk = 1'b1;
		$display("test compensation done");
		hcmd(1'b1, doze, 1'b0, 1'b0, 5'h00, 16'h0000);
		exp_md = doze;
		await_note(6'h02);
		finger[0] = v;
		{exp_b, exp_md} = {8'h01, act};
		await_note(6'h02);
		finger[0] = 16'h0000;
		exp_b = 8'h00;
		await_note(6'h20);
		hcmd(1'b0, act, 1'b0, 1'b1, touch_pkg::A_WAKE_SEQ, 16'hA001);
		hcmd(1'b1, doze, 1'b0, 1'b0, 5'h00, 16'h0000);
		exp_md = doze;
		await_note(6'h02);
		for (int k = 3; k >= 0; k--) begin
			finger[k[1] ? 1 : 0] = k[0] ? v : 16'h0000;
			exp_b = k[0] ? (k[1] ? 8'h02 : 8'h01) : 8'h00;
			exp_md = (k == 0) ? act : doze;
			await_note((k == 0) ? 6'h02 : 6'h20);
		end
		$display("test modes done");
		hcmd(1'b1, touch_pkg::MODE_SLEEP, 1'b0, 1'b0, 5'h00, 16'h0000);
		hcmd(1'b0, act, 1'b1, 1'b0, 5'h00, 16'h0000);
		repeat (1500) @(posedge mclk_i);
		s = n_start;
		repeat (1000) @(posedge mclk_i);
		cmp("sleep_starts", 32'(s), 32'(n_start));
		hcmd(1'b1, act, 1'b0, 1'b0, 5'h00, 16'h0000);
		exp_md = act;
		await_note(6'h02);
		$display("test sleep done");
		// second reset from a valid stored set: starts must follow its enable word
		chk = 1'b0;
		boot(1'b1);
		exp_p = 16'h0000;
		await_note(6'h01);
		hcmd(1'b0, act, 1'b0, 1'b1, touch_pkg::A_PASSIVE, 16'h0002);
		exp_md = doze;
		await_note(6'h02);
		$display("test nvm_boot done");
		conclude();
	end
endmodule
`default_nettype wire
